// >>> hdl/cm_reconfig_pkg.sv
// Package with constants, types and ROM layout for the clock manager reconfiguration sequencer.
// Assumes a single 200 MHz system clock and a synchronous active-low reset.
package cm_reconfig_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int NUM_STATES = 2;
  localparam int SEL_W = 1;
  localparam int FULL_COUNT = 24;
  localparam int DROP_COUNT = 2;
  localparam logic [ADDR_W-1:0] OUT4_REG_A = 7'h10;
  localparam logic [ADDR_W-1:0] OUT4_REG_B = 7'h11;
  localparam int ROM_IDX_W = 6;
  localparam logic [ROM_IDX_W-1:0] ROM_IDX_RESET = 6'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] data;
  } rom_entry_type;

  typedef struct packed {
    logic den;
    logic dwe;
    logic [ADDR_W-1:0] daddr;
    logic [DATA_W-1:0] di;
  } port_req_type;

  typedef enum logic [2:0] {
    ST_RESTART = 3'b000,
    ST_IDLE_WAIT = 3'b001,
    ST_ADDRESS = 3'b010,
    ST_READ_WAIT = 3'b011,
    ST_WRITE = 3'b100,
    ST_WRITE_WAIT = 3'b101,
    ST_NEXT = 3'b110
  } seq_state_type;

endpackage : cm_reconfig_pkg

// >>> hdl/cm_reconfig_rom.sv
// Entry ROM holding the register writes of every configuration state.
// Assumes the caller indexes it with a state base plus an entry offset.
module cm_reconfig_rom
  import cm_reconfig_pkg::*;
#(
  parameter bit KEEP_OUT4 = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic [ROM_IDX_W-1:0] idx_i,
  output rom_entry_type entry_o
);

  localparam int STATE_COUNT = KEEP_OUT4 ? FULL_COUNT - DROP_COUNT : FULL_COUNT;
  localparam int DEPTH = NUM_STATES * STATE_COUNT;

  rom_entry_type rom_mem [DEPTH];

  // Register addresses run 0x06..0x1D; output four's pair is skipped when kept.
  function automatic logic [ADDR_W-1:0] reg_addr(input int k);
    int a;
    a = k + 6;
    if (KEEP_OUT4 && a >= 16) begin
      a = a + DROP_COUNT;
    end
    return a[ADDR_W-1:0];
  endfunction : reg_addr

  // The loop already covers every state; further states need a larger NUM_STATES and a wider ROM_IDX_W, as 6 bits index only 64 entries.
  generate
    for (genvar s = 0; s < NUM_STATES; s++) begin : g_state
      for (genvar k = 0; k < STATE_COUNT; k++) begin : g_entry
        assign rom_mem[s*STATE_COUNT+k] = '{addr: reg_addr(k), mask: 16'h0000,
                                           data: {8'(s), 8'(k)}};
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    entry_o <= rom_mem[idx_i];
  end

endmodule : cm_reconfig_rom

// >>> hdl/cm_reconfig_seq.sv
// Sequencer that plays a stored configuration state into the clock manager reconfiguration port.
// Assumes the port acknowledges each access with a one-cycle ready pulse.
//
// Summary of operation
// - Two configuration states, generated by one loop and sharing KEEP_OUT4, are stored and either may be loaded.
// - State select 0 loads the first state and 1 loads the second.
// - A one-cycle start pulse makes the sequencer write every register of the chosen state.
// - Ready returns once all writes are done and the clock manager runs the new setup.
// - Entries sit at consecutive ROM addresses and are written in order, one write each.
// - The per-state write count is 24, or 22 when two registers are dropped.
// - Keeping output four's setting omits writes to registers 0x10 and 0x11.
// - While idle the start ROM address follows the state select input.
// - More states are added by widening the select and ROM_IDX_W and raising NUM_STATES, whose loop generates the ROM contents.
// - The port clock output is the system clock forwarded directly.
// - The clock manager reset is held during a load and whenever the own reset is low.
module cm_reconfig_seq
  import cm_reconfig_pkg::*;
#(
  parameter bit KEEP_OUT4 = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [SEL_W-1:0] state_select_i,
  input wire logic reconfig_start_pulse_i,
  input wire logic [DATA_W-1:0] port_do_i,
  input wire logic port_drdy_i,
  input wire logic port_locked_i,
  output logic sequencer_ready_o,
  output logic port_clock_out_o,
  output port_req_type port_req_o,
  output logic cm_reset_o
);

  localparam int STATE_COUNT = KEEP_OUT4 ? FULL_COUNT - DROP_COUNT : FULL_COUNT;
  localparam logic [ROM_IDX_W-1:0] COUNT_CONST = ROM_IDX_W'(STATE_COUNT);

  seq_state_type state_ff;
  seq_state_type nxt_state;
  logic [ROM_IDX_W-1:0] rom_idx_ff;
  logic [ROM_IDX_W-1:0] left_ff;
  logic [ROM_IDX_W-1:0] nxt_idx;
  logic [ROM_IDX_W-1:0] nxt_left;
  rom_entry_type entry;
  port_req_type nxt_req;
  logic [DATA_W-1:0] rd_data_ff;

  // One decode serves the ROM index, the ready output and the clock manager reset.
  function automatic logic is_idle(input seq_state_type s);
    return (s == ST_IDLE_WAIT);
  endfunction : is_idle

  // First ROM entry of the selected configuration state.
  function automatic logic [ROM_IDX_W-1:0] state_base(input logic [SEL_W-1:0] sel);
    return ROM_IDX_W'(sel * STATE_COUNT);
  endfunction : state_base

  cm_reconfig_rom #(
    .KEEP_OUT4(KEEP_OUT4)
  ) u_rom (
    .clk_sys_i(clk_sys_i),
    .idx_i(nxt_idx),
    .entry_o(entry)
  );

  // A clock forwarded through logic would add skew; a plain wire keeps the port in phase.
  assign port_clock_out_o = clk_sys_i;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESTART: begin
        nxt_state = ST_IDLE_WAIT;
      end
      ST_IDLE_WAIT: begin
        if (reconfig_start_pulse_i) begin
          nxt_state = ST_ADDRESS;
        end
      end
      ST_ADDRESS: begin
        nxt_state = ST_READ_WAIT;
      end
      ST_READ_WAIT: begin
        if (port_drdy_i) begin
          nxt_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        nxt_state = ST_WRITE_WAIT;
      end
      ST_WRITE_WAIT: begin
        if (port_drdy_i) begin
          nxt_state = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (left_ff == ROM_IDX_RESET) begin
          nxt_state = ST_IDLE_WAIT;
        end else begin
          nxt_state = ST_ADDRESS;
        end
      end
      default: begin
        nxt_state = ST_RESTART;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_RESTART;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
    end
  end

  // The ROM registers its output, so it is addressed with the next index.
  // The entry that stands during a request then belongs to the index held in rom_idx_ff,
  // even when the select changes in the very cycle of the start pulse.
  always_comb begin
    nxt_idx = rom_idx_ff;
    nxt_left = left_ff;
    if (!reset_n_i) begin
      nxt_idx = ROM_IDX_RESET;
      nxt_left = ROM_IDX_RESET;
    end else if (clk_en_i) begin
      if (is_idle(state_ff)) begin
        nxt_idx = state_base(state_select_i);
        nxt_left = COUNT_CONST - 6'h01;
      end else if (state_ff == ST_NEXT && left_ff != ROM_IDX_RESET) begin
        nxt_idx = rom_idx_ff + 6'h01;
        nxt_left = left_ff - 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    rom_idx_ff <= nxt_idx;
  end

  always_ff @(posedge clk_sys_i) begin
    left_ff <= nxt_left;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rd_data_ff <= '0;
    end else if (clk_en_i && state_ff == ST_READ_WAIT && port_drdy_i) begin
      rd_data_ff <= port_do_i;
    end
  end

  // Read-modify-write keeps the read bits inside each entry's mask and ORs the entry data over them.
  always_comb begin
    nxt_req = '0;
    nxt_req.daddr = entry.addr;
    if (state_ff == ST_ADDRESS) begin
      nxt_req.den = 1'b1;
    end else if (state_ff == ST_WRITE) begin
      nxt_req.den = 1'b1;
      nxt_req.dwe = 1'b1;
      nxt_req.di = (rd_data_ff & entry.mask) | entry.data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      port_req_o <= '0;
    end else if (clk_en_i) begin
      port_req_o <= nxt_req;
    end
  end

  // Ready also waits for lock, but a start pulse in ST_IDLE_WAIT begins a load whether or not the clock manager is locked.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sequencer_ready_o <= 1'b0;
    end else if (clk_en_i) begin
      sequencer_ready_o <= is_idle(nxt_state) && port_locked_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cm_reset_o <= 1'b1;
    end else if (clk_en_i) begin
      cm_reset_o <= !is_idle(nxt_state);
    end
  end

endmodule : cm_reconfig_seq

// >>> verification/cm_port_model.sv
// Port model: acks each access after a random delay.
// Assumes one request at a time.
module cm_port_model
  import cm_reconfig_pkg::*;
(
  input wire logic clk_sys_i,
  input wire port_req_type port_req_i,
  input wire logic cm_reset_i,
  output logic port_drdy_o = 1'b0,
  output logic [DATA_W-1:0] port_do_o = '0,
  output logic port_locked_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge clk_sys_i) begin
    // Data churns so only the acked value means anything.
    port_do_o <= DATA_W'($urandom);
    port_locked_o <= !cm_reset_i;
    port_drdy_o <= (cnt == 1);
    if (port_req_i.den === 1'b1) cnt <= 1 + $urandom_range(4, 0);
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : cm_port_model

// >>> verification/cm_reconfig_seq_asserts.sv
// Port checks for the sequencer.
// Assumes the clock enable only drops while the sequencer is idle.
module cm_reconfig_seq_asserts
  import cm_reconfig_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic reconfig_start_pulse_i,
  input wire logic port_drdy_i,
  input wire logic sequencer_ready_o,
  input wire port_req_type port_req_o,
  input wire logic cm_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_ff;
  wire logic go = reconfig_start_pulse_i && sequencer_ready_o && clk_en_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) pend_ff <= 1'b0;
    else if (port_req_o.den) pend_ff <= 1'b1;
    else if (port_drdy_i) pend_ff <= 1'b0;
  end
  ready_idle_a: assert property (sequencer_ready_o |-> !cm_reset_o)
    else $error("ready while busy");
  reset_hold_a: assert property (disable iff (1'b0) !reset_n_i |=> cm_reset_o)
    else $error("no reset out");
  start_taken_a: assert property (go |=> !sequencer_ready_o && cm_reset_o)
    else $error("start lost");
  first_read_a: assert property (go |-> ##2 port_req_o.den && !port_req_o.dwe)
    else $error("no first read");
  req_busy_a: assert property (port_req_o.den |-> cm_reset_o)
    else $error("req out of load");
  dwe_den_a: assert property (port_req_o.dwe |-> port_req_o.den)
    else $error("lone write");
  ack_wait_a: assert property (port_req_o.den |-> !pend_ff)
    else $error("no ack wait");
  den_pulse_a: assert property (port_req_o.den |=> !port_req_o.den)
    else $error("long request");
endmodule : cm_reconfig_seq_asserts
bind cm_reconfig_seq cm_reconfig_seq_asserts i_chk (.clk_sys_i, .reset_n_i, .clk_en_i,
  .reconfig_start_pulse_i, .port_drdy_i, .sequencer_ready_o, .port_req_o, .cm_reset_o);

// >>> verification/tb_top.sv
// Bench for the sequencer with output four kept.
// Assumes the port model acks within a few cycles.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
  import cm_reconfig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, go = 1'b0, drdy, lock, rdy, cmr, pclk;
  logic [SEL_W-1:0] sel = '0;
  logic en = 1'b1;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] di_tab [2][22];
  logic [ADDR_W-1:0] rd_a;
  port_req_type req;
  bit seen [2];
  int err_total = 0, total_checks = 0, widx = 0, cur = 0;
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  cm_reconfig_seq #(.KEEP_OUT4(1'b1)) i_dut (.clk_sys_i, .reset_n_i, .clk_en_i(en),
    .state_select_i(sel), .reconfig_start_pulse_i(go), .port_do_i(rd), .port_drdy_i(drdy),
    .port_locked_i(lock), .sequencer_ready_o(rdy), .port_clock_out_o(pclk),
    .port_req_o(req), .cm_reset_o(cmr));
  cm_port_model i_port (.clk_sys_i, .port_req_i(req), .cm_reset_i(cmr),
    .port_drdy_o(drdy), .port_do_o(rd), .port_locked_o(lock));
  always @(negedge clk_sys_i) begin
    `CHK(pclk, clk_sys_i)
    if (req.den === 1'b1 && req.dwe !== 1'b1) rd_a = req.daddr;
    if (req.den === 1'b1 && req.dwe === 1'b1) begin
      // Registers 0x10 and 0x11 are skipped.
      `CHK(req.daddr, ADDR_W'(widx + ((widx > 9) ? 8 : 6)))
      `CHK(req.daddr, rd_a)
      `CHK(req.di, {8'(cur), 8'(widx)})
      if (seen[cur]) `CHK(req.di, di_tab[cur][widx])
      else di_tab[cur][widx] = req.di;
      widx++;
    end
  end
  task automatic load(input logic [SEL_W-1:0] s);
    do begin @(posedge clk_sys_i); #1; end while (rdy !== 1'b1);
    @(posedge clk_sys_i);
    en <= 1'b0;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    @(posedge clk_sys_i);
    en <= 1'b1;
    #1 `CHK(rdy, 1'b1)
    @(posedge clk_sys_i);
    sel <= s;
    go <= 1'b1;
    widx = 0;
    cur = s;
    @(posedge clk_sys_i);
    go <= 1'b0;
    sel <= SEL_W'($urandom);
    repeat (6) @(posedge clk_sys_i);
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    do begin @(posedge clk_sys_i); #1; end while (rdy !== 1'b1);
    `CHK(widx, 22)
    `CHK(cmr, 1'b0)
    seen[cur] = 1'b1;
  endtask : load
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(75));
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int n = 0; n < 6; n++) load((n < 2) ? n[0] : SEL_W'($urandom));
    `CHK(di_tab[0][0] !== di_tab[1][0], 1'b1)
    tally_and_finish();
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule : tb_top
